// ### hdl/fatv_cell_detector.sv
`timescale 1ns/1ns
`include "fatv_defs.svh"

module fatv_cell_detector
  import fatv_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Cell signal and setpoints
  input wire logic enable,
  input wire logic [15:0] cell_sig,
  input wire logic [15:0] amp_alarm,
  input wire logic [15:0] amp_trip,
  input wire logic [15:0] period_max,
  // Flags
  output logic alarm,
  output logic trip
);

  fatv_det_t st_reg;
  fatv_det_t st_next;

  // ---------------------------------------------------------------
  // Peak and period tracking around a slow mean
  // ---------------------------------------------------------------
  always_comb
  begin
    logic signed [16:0] dev;
    logic [16:0] mag;
    logic [16:0] step;
    dev = 17'($signed({1'b0, cell_sig}) - $signed({1'b0, st_reg.mean}));
    mag = dev[16] ? 17'(-dev) : dev;
    step = 17'(dev >>> `FATV_FILT_SHIFT);
    st_next = st_reg;
    st_next.mean = 16'(17'({1'b0, st_reg.mean}) + step);
    st_next.sign = ~dev[16] && (dev != 17'h00000);
    if (mag[15:0] > st_reg.peak)
    begin
      st_next.peak = mag[15:0];
    end
    if (st_reg.period_cnt != 16'hffff)
    begin
      st_next.period_cnt = st_reg.period_cnt + 16'h0001;
    end
    // Judge each full cycle at the upward crossing
    if (st_next.sign && !st_reg.sign)
    begin
      st_next.alarm = enable && (st_reg.peak > amp_alarm)
                      && (st_reg.period_cnt <= period_max);
      st_next.trip = enable && (st_reg.peak > amp_trip)
                     && (st_reg.period_cnt <= period_max);
      st_next.peak = 16'h0000;
      st_next.period_cnt = 16'h0000;
    end
    if (!enable)
    begin
      st_next.alarm = 1'b0;
      st_next.trip = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign alarm = st_reg.alarm;
  assign trip = st_reg.trip;

endmodule

// ### hdl/fatv_channel.sv
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ns
`include "fatv_defs.svh"

module fatv_channel
  import fatv_pkg::*;
#(
  parameter int CHAN_INDEX = 0
)
(
  // Clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Plant inputs
  input wire logic [63:0][15:0] LOCAL_FLUX_INPUT,
  input wire logic MODE_RUN,
  input wire logic [3:0] BYP_SEL,
  // Channel status and trips
  output logic UPSCALE_TRIP,
  output logic DOWNSCALE_TRIP,
  output logic INOP_TRIP,
  output logic BYPASSED_STATUS,
  output logic BYP_FAULT,
  output logic [15:0] CORE_AVG,
  // Toward the divisions and panel
  output logic [3:0] DIV_TRIP,
  output logic [3:0] DIV_BYPASS,
  output logic PANEL_BYPASS_IND,
  output logic ATL_PERMISSIVE,
  // Oscillation monitor
  output logic OSC_ALARM,
  output logic OSC_TRIP,
  output logic OSC_INOP_ALARM
);

  fatv_state_t st_reg;
  fatv_state_t st_next;
  logic [15:0] det_alarm;
  logic [15:0] det_trip;

  // ---------------------------------------------------------------
  // Per-cell oscillation detectors
  // ---------------------------------------------------------------
  for (genvar g = 0; g < `FATV_NUM_CELLS; g++)
  begin : g_det
    fatv_cell_detector u_det (
      .clk(CLK),
      .arst_n(ARST_N),
      .enable(st_reg.res.osc_en),
      .cell_sig(st_reg.res.cell_sig[g]),
      .amp_alarm(st_reg.cfg.amp_alarm),
      .amp_trip(st_reg.cfg.amp_trip),
      .period_max(st_reg.cfg.period_sp),
      .alarm(det_alarm[g]),
      .trip(det_trip[g])
    );
  end

  // ---------------------------------------------------------------
  // Averaging, trips and register access
  // ---------------------------------------------------------------
  always_comb
  begin
    logic [21:0] sum;
    logic [6:0] cnt;
    logic [6:0] nbyp;
    logic [15:0] mean;
    logic [31:0] norm;
    logic [21:0] csum;
    logic [2:0] ccnt;
    logic [4:0] okcnt;
    logic [5:0] ix;
    logic [31:0] rd;
    logic valid;
    logic ro;
    sum = 22'h000000;
    cnt = 7'h00;
    nbyp = 7'h00;
    okcnt = 5'h00;
    mean = 16'h0000;
    norm = 32'h00000000;
    csum = 22'h000000;
    ccnt = 3'h0;
    ix = 6'h00;
    rd = 32'h00000000;
    valid = 1'b1;
    ro = 1'b0;
    st_next = st_reg;

    for (int i = 0; i < `FATV_NUM_IN; i++)
    begin
      if (!st_reg.cfg.lfi_byp[i])
      begin
        sum = sum + 22'(LOCAL_FLUX_INPUT[i]);
        cnt = cnt + 7'h01;
      end
      else
      begin
        nbyp = nbyp + 7'h01;
      end
    end
    mean = fatv_mean(sum, cnt);
    norm = (32'(mean) * 32'(st_reg.cfg.gain)) >> `FATV_GAIN_SHIFT;
    st_next.res.avg = (norm > 32'h0000ffff) ? 16'hffff : norm[15:0];

    for (int c = 0; c < `FATV_NUM_CELLS; c++)
    begin
      csum = 22'h000000;
      ccnt = 3'h0;
      for (int k = 0; k < `FATV_CELL_MAX; k++)
      begin
        ix = st_reg.cfg.cells[c].idx[k];
        if ((3'(k) < st_reg.cfg.cells[c].size) && !st_reg.cfg.lfi_byp[ix])
        begin
          csum = csum + 22'(LOCAL_FLUX_INPUT[ix]);
          ccnt = ccnt + 3'h1;
        end
      end
      st_next.res.cell_sig[c] = fatv_mean(csum, 7'(ccnt));
      st_next.res.cell_ok[c] = (ccnt != 3'h0)
                               && (ccnt >= st_reg.cfg.min_cin);
      if (st_next.res.cell_ok[c])
      begin
        okcnt = okcnt + 5'h01;
      end
    end
    st_next.res.osc_inop = okcnt < st_reg.cfg.min_cells;

    st_next.res.active_sp = MODE_RUN ? st_reg.cfg.up_sp
                                     : st_reg.cfg.setdown_sp;
    st_next.res.up = st_next.res.avg > st_next.res.active_sp;
    st_next.res.down = st_next.res.avg < st_reg.cfg.down_sp;
    st_next.res.inop = (nbyp > st_reg.cfg.max_byp)
                       || (cnt == 7'h00);
    st_next.res.byp_fault = !fatv_onehot0(BYP_SEL);
    st_next.res.bypassed = !st_next.res.byp_fault
                           && BYP_SEL[CHAN_INDEX];
    st_next.res.perm = st_next.res.avg >= st_reg.cfg.perm_sp;
    st_next.res.osc_en = MODE_RUN
                         && (st_reg.res.avg >= st_reg.cfg.osc_pwr_sp);
    st_next.res.osc_alarm = st_reg.res.osc_en && MODE_RUN
                            && (|det_alarm);
    st_next.res.osc_trip = st_reg.res.osc_en && MODE_RUN
                           && (|det_trip);
    st_next.res.div_trip = !st_next.res.bypassed
                           && (st_next.res.up || st_next.res.inop
                               || st_next.res.osc_trip);

    case (PADDR)
      `FATV_REG_UP_SP: rd = {16'h0000, st_reg.cfg.up_sp};
      `FATV_REG_DOWN_SP: rd = {16'h0000, st_reg.cfg.down_sp};
      `FATV_REG_SETDOWN_SP: rd = {16'h0000, st_reg.cfg.setdown_sp};
      `FATV_REG_PERM_SP: rd = {16'h0000, st_reg.cfg.perm_sp};
      `FATV_REG_OSC_PWR_SP: rd = {16'h0000, st_reg.cfg.osc_pwr_sp};
      `FATV_REG_AMP_ALARM: rd = {16'h0000, st_reg.cfg.amp_alarm};
      `FATV_REG_AMP_TRIP: rd = {16'h0000, st_reg.cfg.amp_trip};
      `FATV_REG_PERIOD_SP: rd = {16'h0000, st_reg.cfg.period_sp};
      `FATV_REG_GAIN: rd = {16'h0000, st_reg.cfg.gain};
      `FATV_REG_LIMITS: rd = {11'h000, st_reg.cfg.min_cells, 5'h00,
                              st_reg.cfg.min_cin, 1'b0,
                              st_reg.cfg.max_byp};
      `FATV_REG_BYP_LO: rd = st_reg.cfg.lfi_byp[31:0];
      `FATV_REG_BYP_HI: rd = st_reg.cfg.lfi_byp[63:32];
      `FATV_REG_AVG: {ro, rd} = {1'b1, 16'h0000, st_reg.res.avg};
      `FATV_REG_STATUS: {ro, rd} = {1'b1, 21'h000000,
                                    st_reg.res.div_trip, st_reg.res.osc_inop,
                                    st_reg.res.osc_trip, st_reg.res.osc_alarm,
                                    st_reg.res.perm, st_reg.res.byp_fault,
                                    st_reg.res.bypassed, st_reg.res.inop,
                                    st_reg.res.down, st_reg.res.up};
      `FATV_REG_CELL_OK: {ro, rd} = {1'b1, 16'h0000, st_reg.res.cell_ok};
      default:
      begin
        if ((PADDR[7:6] == `FATV_REG_CELL_BASE) && (PADDR[1:0] == 2'h0))
        begin
          rd = {5'h00, st_reg.cfg.cells[PADDR[5:2]]};
        end
        else
        begin
          valid = 1'b0;
        end
      end
    endcase

    // One wait state: read data latched on the same edge as ready; writes commit on the edge after
    if (PSEL && PENABLE && !st_reg.apb.ack)
    begin
      st_next.apb.ack = 1'b1;
      st_next.apb.err = !valid || (PWRITE && ro);
      st_next.apb.rdata = PWRITE ? 32'h00000000 : rd;
    end
    else if (st_reg.apb.ack)
    begin
      st_next.apb.ack = 1'b0;
      if (PWRITE && !st_reg.apb.err)
      begin
        case (PADDR)
          `FATV_REG_UP_SP: st_next.cfg.up_sp = PWDATA[15:0];
          `FATV_REG_DOWN_SP: st_next.cfg.down_sp = PWDATA[15:0];
          `FATV_REG_SETDOWN_SP: st_next.cfg.setdown_sp = PWDATA[15:0];
          `FATV_REG_PERM_SP: st_next.cfg.perm_sp = PWDATA[15:0];
          `FATV_REG_OSC_PWR_SP: st_next.cfg.osc_pwr_sp = PWDATA[15:0];
          `FATV_REG_AMP_ALARM: st_next.cfg.amp_alarm = PWDATA[15:0];
          `FATV_REG_AMP_TRIP: st_next.cfg.amp_trip = PWDATA[15:0];
          `FATV_REG_PERIOD_SP: st_next.cfg.period_sp = PWDATA[15:0];
          `FATV_REG_GAIN: st_next.cfg.gain = PWDATA[15:0];
          `FATV_REG_LIMITS:
          begin
            st_next.cfg.max_byp = PWDATA[`FATV_LIM_MAXBYP_LSB +: 7];
            st_next.cfg.min_cin = PWDATA[`FATV_LIM_MINCIN_LSB +: 3];
            st_next.cfg.min_cells = PWDATA[`FATV_LIM_MINCELL_LSB +: 5];
          end
          `FATV_REG_BYP_LO: st_next.cfg.lfi_byp[31:0] = PWDATA;
          `FATV_REG_BYP_HI: st_next.cfg.lfi_byp[63:32] = PWDATA;
          default:
          begin
            st_next.cfg.cells[PADDR[5:2]] =
              fatv_cell_t'(PWDATA[`FATV_CELL_W-1:0]);
          end
        endcase
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      st_reg <= fatv_state_rst();
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign PRDATA = st_reg.apb.rdata;
  assign PREADY = st_reg.apb.ack;
  assign PSLVERR = st_reg.apb.ack && st_reg.apb.err;
  assign UPSCALE_TRIP = st_reg.res.up;
  assign DOWNSCALE_TRIP = st_reg.res.down;
  assign INOP_TRIP = st_reg.res.inop;
  assign BYPASSED_STATUS = st_reg.res.bypassed;
  assign BYP_FAULT = st_reg.res.byp_fault;
  assign CORE_AVG = st_reg.res.avg;
  assign DIV_TRIP = {4{st_reg.res.div_trip}};
  assign DIV_BYPASS = {4{st_reg.res.bypassed}};
  assign PANEL_BYPASS_IND = |DIV_BYPASS;
  assign ATL_PERMISSIVE = st_reg.res.perm;
  assign OSC_ALARM = st_reg.res.osc_alarm;
  assign OSC_TRIP = st_reg.res.osc_trip;
  assign OSC_INOP_ALARM = st_reg.res.osc_inop;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);

  sequence s_leave_run;
    $fell(MODE_RUN);
  endsequence

  sequence s_access_wait;
    PSEL && PENABLE && !PREADY;
  endsequence

  a_setdown_used: assert property (s_leave_run |=>
    st_reg.res.active_sp == $past(st_reg.cfg.setdown_sp))
    else $error("setdown setpoint not used outside run");
  a_bypass_single: assert property (BYPASSED_STATUS |->
    $past(fatv_onehot0(BYP_SEL)))
    else $error("bypass accepted with several positions");
  a_bypass_manual: assert property ($rose(BYPASSED_STATUS) |->
    $past(BYP_SEL[CHAN_INDEX]))
    else $error("bypass without selector");
  a_trip_fanout: assert property (DIV_TRIP == {4{DIV_TRIP[0]}})
    else $error("division trips differ");
  a_bypass_drops: assert property (BYPASSED_STATUS |->
    DIV_TRIP == 4'h0 && PANEL_BYPASS_IND)
    else $error("bypassed channel still trips");
  a_osc_gated: assert property ((OSC_TRIP || OSC_ALARM) |->
    $past(MODE_RUN) && $past(MODE_RUN, 2))
    else $error("oscillation output outside run");
  a_osc_merged: assert property (OSC_TRIP && !BYPASSED_STATUS |->
    DIV_TRIP[0])
    else $error("oscillation trip not merged");
  a_inop_cause: assert property (INOP_TRIP |->
    ($past($countones(st_reg.cfg.lfi_byp)) > $past(32'(st_reg.cfg.max_byp)))
    || ($past(st_reg.cfg.lfi_byp) == 64'hffffffffffffffff))
    else $error("inoperative trip without cause");
  a_osc_inop_alarm: assert property ($rose(OSC_INOP_ALARM) |->
    $past($countones(st_next.res.cell_ok) < 32'(st_reg.cfg.min_cells)))
    else $error("oscillation inop alarm without cause");
  a_apb_answer: assert property (s_access_wait |=> PREADY)
    else $error("apb answer late");

endmodule

// ### hdl/fatv_defs.svh
// Summary of operation
// - Average the 64 local flux inputs and normalize to core-average power.
// - Divide only by the count of inputs that are not bypassed.
// - Upscale, downscale, bypassed, inop outputs; setpoints adjustable.
// - At most one channel bypassed; selector positions exclusive, checked.
// - Channel trip goes to all four divisions; voting never stops.
// - Channel bypass comes only from the manual selector, never automatic.
// - Outside Run mode the lower setdown trip setpoint is used.
// - Any bypassed division output raises the panel bypass indication.
// - Channel bypass suppresses core-average and oscillation trips together.
// - Channel sends a permissive to the anticipated transient logic.
// - Oscillation cells group at most four of the channel's inputs.
// - Cell signal is the mean of its operating grouped inputs.
// - Cell inoperable when operating inputs fall below configured minimum.
// - Too few operable cells gives an inop alarm, never a trip.
// - Any cell over alarm or trip setpoint drives the channel output.
// - Oscillation trip merged with core-average trips toward divisions.
// - Oscillation alarm and trip only in Run and at or above power threshold.
// - Too many bypassed inputs raises the inoperative trip.
`ifndef FATV_DEFS_SVH
`define FATV_DEFS_SVH

// ---------------------------------------------------------------
// Sizes
// ---------------------------------------------------------------
`define FATV_NUM_IN 64
`define FATV_NUM_CELLS 16
`define FATV_CELL_MAX 4
`define FATV_DW 16
`define FATV_GAIN_SHIFT 12
`define FATV_FILT_SHIFT 4

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define FATV_REG_UP_SP 8'h00
`define FATV_REG_DOWN_SP 8'h04
`define FATV_REG_SETDOWN_SP 8'h08
`define FATV_REG_PERM_SP 8'h0c
`define FATV_REG_OSC_PWR_SP 8'h10
`define FATV_REG_AMP_ALARM 8'h14
`define FATV_REG_AMP_TRIP 8'h18
`define FATV_REG_PERIOD_SP 8'h1c
`define FATV_REG_GAIN 8'h20
`define FATV_REG_LIMITS 8'h24
`define FATV_REG_BYP_LO 8'h28
`define FATV_REG_BYP_HI 8'h2c
`define FATV_REG_AVG 8'h30
`define FATV_REG_STATUS 8'h34
`define FATV_REG_CELL_OK 8'h38
`define FATV_REG_CELL_BASE 2'h1

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define FATV_LIM_MAXBYP_LSB 0
`define FATV_LIM_MINCIN_LSB 8
`define FATV_LIM_MINCELL_LSB 16
`define FATV_CELL_W 27

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define FATV_RST_UP_SP 16'hc000
`define FATV_RST_DOWN_SP 16'h0800
`define FATV_RST_SETDOWN_SP 16'h4000
`define FATV_RST_PERM_SP 16'h1000
`define FATV_RST_OSC_PWR_SP 16'h4ccd
`define FATV_RST_AMP_ALARM 16'h0400
`define FATV_RST_AMP_TRIP 16'h0800
`define FATV_RST_PERIOD_SP 16'h0100
`define FATV_RST_GAIN 16'h1000
`define FATV_RST_MAXBYP 7'h10
`define FATV_RST_MINCIN 3'h2
`define FATV_RST_MINCELL 5'h08

`endif

// ### hdl/fatv_pkg.sv
`include "fatv_defs.svh"

package fatv_pkg;

  typedef struct packed {
    logic [2:0] size;
    logic [3:0][5:0] idx;
  } fatv_cell_t;

  typedef struct packed {
    logic [15:0] up_sp;
    logic [15:0] down_sp;
    logic [15:0] setdown_sp;
    logic [15:0] perm_sp;
    logic [15:0] osc_pwr_sp;
    logic [15:0] amp_alarm;
    logic [15:0] amp_trip;
    logic [15:0] period_sp;
    logic [15:0] gain;
    logic [6:0] max_byp;
    logic [2:0] min_cin;
    logic [4:0] min_cells;
    logic [63:0] lfi_byp;
    fatv_cell_t [15:0] cells;
  } fatv_cfg_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
  } fatv_apb_t;

  typedef struct packed {
    logic [15:0] avg;
    logic [15:0] active_sp;
    logic up;
    logic down;
    logic inop;
    logic bypassed;
    logic byp_fault;
    logic perm;
    logic osc_en;
    logic osc_alarm;
    logic osc_trip;
    logic osc_inop;
    logic div_trip;
    logic [15:0] cell_ok;
    logic [15:0][15:0] cell_sig;
  } fatv_res_t;

  typedef struct packed {
    fatv_cfg_t cfg;
    fatv_apb_t apb;
    fatv_res_t res;
  } fatv_state_t;

  typedef struct packed {
    logic [15:0] mean;
    logic [15:0] peak;
    logic [15:0] period_cnt;
    logic sign;
    logic alarm;
    logic trip;
  } fatv_det_t;

  function automatic logic [15:0] fatv_mean(input logic [21:0] sum,
                                            input logic [6:0] n);
    logic [21:0] q;
    q = (n == 7'h00) ? 22'h000000 : sum / {15'h0000, n};
    return q[15:0];
  endfunction

  function automatic logic fatv_onehot0(input logic [3:0] x);
    return (x & (x - 4'h1)) == 4'h0;
  endfunction

  function automatic fatv_state_t fatv_state_rst();
    fatv_state_t s;
    s = '0;
    s.cfg.up_sp = `FATV_RST_UP_SP;
    s.cfg.down_sp = `FATV_RST_DOWN_SP;
    s.cfg.setdown_sp = `FATV_RST_SETDOWN_SP;
    s.cfg.perm_sp = `FATV_RST_PERM_SP;
    s.cfg.osc_pwr_sp = `FATV_RST_OSC_PWR_SP;
    s.cfg.amp_alarm = `FATV_RST_AMP_ALARM;
    s.cfg.amp_trip = `FATV_RST_AMP_TRIP;
    s.cfg.period_sp = `FATV_RST_PERIOD_SP;
    s.cfg.gain = `FATV_RST_GAIN;
    s.cfg.max_byp = `FATV_RST_MAXBYP;
    s.cfg.min_cin = `FATV_RST_MINCIN;
    s.cfg.min_cells = `FATV_RST_MINCELL;
    for (int c = 0; c < `FATV_NUM_CELLS; c++)
    begin
      s.cfg.cells[c].size = 3'h4;
      for (int k = 0; k < `FATV_CELL_MAX; k++)
      begin
        s.cfg.cells[c].idx[k] = 6'(c * 4 + k);
      end
    end
    return s;
  endfunction

endpackage

// ### test/fatv_voter_model.sv
`timescale 1ns/1ns

module fatv_voter_model
(
  // Channel trips and bypass flags, one set per division
  input wire logic [3:0][3:0] trip,
  input wire logic [3:0][3:0] byp,
  // Division scram demand
  output logic [3:0] vote
);

  // ----------------------------------------------------------
  // One division voter
  // ----------------------------------------------------------
  function automatic logic vote_one(input logic [3:0] t,
                                    input logic [3:0] b);
    logic [3:0] m;
    logic [2:0] n;
    // A pattern with two or more bypasses is ignored
    m = ((b & (b - 4'h1)) == 4'h0) ? b : 4'h0;
    n = 3'h0;
    for (int i = 0; i < 4; i++)
    begin
      n = n + {2'h0, t[i] & ~m[i]};
    end
    return n >= 3'h2;
  endfunction

  always_comb
  begin
    for (int d = 0; d < 4; d++)
    begin
      vote[d] = vote_one(trip[d], byp[d]);
    end
  end

endmodule

// ### test/flux_average_trip_vote_test.sv
`timescale 1ns/1ns

module flux_average_trip_vote_test;

  logic clk, arst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [63:0][15:0] flux;
  logic mode_run, up, down, inop, bysts, bfault, panel, perm;
  logic oalm, otrip, oinop, er;
  logic [3:0] byp_sel, dtrip, dbyp, vote;
  logic [15:0] avg;
  logic [2:0] oth_trip;
  logic [3:0][3:0] vt, vb;
  int fails, comparisons, nt, na, nd;
  logic [7:0] ra [13] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
    8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h40};
  logic [31:0] rv [13] = '{32'hc000, 32'h0800, 32'h4000, 32'h1000,
    32'h4ccd, 32'h0400, 32'h0800, 32'h0100, 32'h1000, 32'h00080210,
    32'h0, 32'h0, 32'h040c2040};

  fatv_channel #(.CHAN_INDEX(0)) u_dut (.CLK(clk), .ARST_N(arst_n),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .LOCAL_FLUX_INPUT(flux), .MODE_RUN(mode_run),
    .BYP_SEL(byp_sel), .UPSCALE_TRIP(up), .DOWNSCALE_TRIP(down),
    .INOP_TRIP(inop), .BYPASSED_STATUS(bysts), .BYP_FAULT(bfault),
    .CORE_AVG(avg), .DIV_TRIP(dtrip), .DIV_BYPASS(dbyp),
    .PANEL_BYPASS_IND(panel), .ATL_PERMISSIVE(perm), .OSC_ALARM(oalm),
    .OSC_TRIP(otrip), .OSC_INOP_ALARM(oinop));

  fatv_voter_model u_voter (.trip(vt), .byp(vb), .vote(vote));

  always_comb
  begin
    for (int d = 0; d < 4; d++)
    begin
      vt[d] = {oth_trip, dtrip[d]};
      vb[d] = {byp_sel[3:1], dbyp[d]};
    end
  end

  initial clk = 1'b0;
  always #50 clk = ~clk;

  // ----------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------
  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task chkb(input logic g, input logic e, input string m);
    chk({31'h0, g}, {31'h0, e}, m);
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rchk(input logic [7:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    chk(rd, e, "read data");
    chkb(er, ee, "read error");
  endtask

  task fl(input logic [15:0] v, input logic run, input logic [3:0] s,
          input logic [2:0] o);
    @(posedge clk);
    flux <= {64{v}};
    mode_run <= run;
    byp_sel <= s;
    oth_trip <= o;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask

  // Square wave on all inputs, flips every 8 cycles
  task osc(input logic [15:0] lo, input logic [15:0] hi,
           input logic run, input logic [3:0] s);
    fl(lo, run, s, 3'h0);
    nt = 0;
    na = 0;
    nd = 0;
    for (int i = 0; i < 192; i++)
    begin
      @(posedge clk);
      flux <= {64{i[3] ? hi : lo}};
      @(negedge clk);
      nt += (otrip === 1'b1) ? 1 : 0;
      na += (oalm === 1'b1) ? 1 : 0;
      nd += (dtrip !== 4'h0) ? 1 : 0;
    end
  endtask

  task done(input string s);
    $display("Test %s finished", s);
  endtask

  task wrap_up;
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    wrap_up;
  end

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial
  begin
    fails = 0;
    comparisons = 0;
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    flux = '0;
    mode_run = 1'b1;
    byp_sel = 4'h0;
    oth_trip = 3'h0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 13; i++)
      rchk(ra[i], rv[i], 1'b0);
    apb(1'b1, 8'h00, 32'h1234);
    rchk(8'h00, 32'h1234, 1'b0);
    apb(1'b1, 8'h00, 32'hc000);
    apb(1'b1, 8'h30, 32'h5);
    chkb(er, 1'b1, "write to read-only");
    rchk(8'h80, 32'h0, 1'b1);
    rchk(8'h02, 32'h0, 1'b1);
    done("registers");
    fl(16'h1000, 1'b1, 4'h0, 3'h0);
    chk({16'h0, avg}, 32'h1000, "average");
    chkb(perm, 1'b1, "permissive at limit");
    rchk(8'h30, 32'h1000, 1'b0);
    fl(16'h0fff, 1'b1, 4'h0, 3'h0);
    chkb(perm, 1'b0, "permissive below");
    apb(1'b1, 8'h28, 32'h20);
    fl(16'h2000, 1'b1, 4'h0, 3'h0);
    @(posedge clk);
    flux[5] <= 16'hffff;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({16'h0, avg}, 32'h2000, "bypassed input excluded");
    apb(1'b1, 8'h28, 32'h0000ffff);
    fl(16'h2000, 1'b1, 4'h0, 3'h0);
    chkb(inop, 1'b0, "inop at max");
    apb(1'b1, 8'h28, 32'h0001ffff);
    fl(16'h2000, 1'b1, 4'h0, 3'h0);
    chkb(inop, 1'b1, "inop above max");
    apb(1'b1, 8'h28, 32'h0);
    done("averaging");
    fl(16'hc000, 1'b1, 4'h0, 3'h0);
    chkb(up, 1'b0, "upscale at setpoint");
    fl(16'hc001, 1'b1, 4'h0, 3'h0);
    chkb(up, 1'b1, "upscale");
    chk({28'h0, dtrip}, 32'hf, "trip to divisions");
    chk({28'h0, vote}, 32'h0, "one of four");
    fl(16'hc001, 1'b1, 4'h0, 3'h1);
    chk({28'h0, vote}, 32'hf, "two of four");
    fl(16'h5000, 1'b0, 4'h0, 3'h0);
    chkb(up, 1'b1, "setdown trip");
    fl(16'h5000, 1'b1, 4'h0, 3'h0);
    chkb(up, 1'b0, "run setpoint");
    fl(16'h0400, 1'b1, 4'h0, 3'h0);
    chkb(down, 1'b1, "downscale");
    chk({28'h0, dtrip}, 32'h0, "downscale not merged");
    done("trips");
    fl(16'hc001, 1'b1, 4'h1, 3'h1);
    chkb(bysts, 1'b1, "bypassed");
    chk({28'h0, dtrip}, 32'h0, "bypass gates trip");
    chk({28'h0, dbyp}, 32'hf, "bypass flags");
    chkb(panel, 1'b1, "panel bypass");
    chk({28'h0, vote}, 32'h0, "one of three");
    fl(16'hc001, 1'b1, 4'h1, 3'h3);
    chk({28'h0, vote}, 32'hf, "two of three");
    fl(16'hc001, 1'b1, 4'h3, 3'h0);
    chkb(bfault, 1'b1, "selector fault");
    chkb(bysts, 1'b0, "no bypass on fault");
    chk({28'h0, dtrip}, 32'hf, "trip kept on fault");
    fl(16'hc001, 1'b1, 4'h0, 3'h0);
    chkb(panel, 1'b0, "no automatic bypass");
    done("bypass");
    osc(16'h6000, 16'ha000, 1'b1, 4'h0);
    chkb(nt > 0, 1'b1, "oscillation trip");
    chkb(na > 0, 1'b1, "oscillation alarm");
    chkb(nd > 0, 1'b1, "oscillation trip merged");
    osc(16'h6000, 16'ha000, 1'b1, 4'h1);
    chkb(nd == 0, 1'b1, "oscillation bypassed");
    osc(16'h6000, 16'ha000, 1'b0, 4'h0);
    chkb(nt + na == 0, 1'b1, "oscillation outside run");
    osc(16'h1000, 16'h3000, 1'b1, 4'h0);
    chkb(nt + na == 0, 1'b1, "oscillation low power");
    done("oscillation");
    apb(1'b1, 8'h24, 32'h0008027f);
    apb(1'b1, 8'h28, 32'h77777777);
    apb(1'b1, 8'h2c, 32'h7);
    fl(16'h8000, 1'b1, 4'h0, 3'h0);
    repeat (4) @(negedge clk);
    chkb(oinop, 1'b1, "too few cells");
    chkb(inop, 1'b0, "no inop trip");
    rchk(8'h38, 32'hfe00, 1'b0);
    apb(1'b1, 8'h2c, 32'h0);
    fl(16'h8000, 1'b1, 4'h0, 3'h0);
    repeat (4) @(negedge clk);
    chkb(oinop, 1'b0, "cells at minimum");
    done("cells");
    wrap_up;
  end

endmodule
